/* File: design/opc_port.sv */
// optical port pin conditioning: tx source mux, invert, carrier modulation,
// rx routing to uart, gpio or lcd segment; axi4-lite config registers.
// assumes pin-side inputs are synchronous to aclk.
module opc_port #(
  parameter int CAR_DIV = opc_pkg::OPC_CAR_DIV_DEF
) (
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  input  wire logic [opc_pkg::OPC_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [opc_pkg::OPC_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  input  wire logic                          segment_pin_map_51,
  input  wire logic                          segment_pin_map_55,
  input  wire logic                          gpio_out_51,
  input  wire logic                          uart_tx_data,
  input  wire logic                          real_energy_pulse,
  input  wire logic                          reactive_energy_pulse,
  input  wire logic                          lcd_segment_51,
  input  wire logic                          optical_rx_pin,
  output logic                               optical_tx_pin,
  output logic                               uart_rx_data,
  output logic                               gpio_in_55,
  output logic                               shared_segment_gpio_55,
  output logic                               bitbang_active
);
  import opc_pkg::*;

  // ==========================================================
  // register file
  logic            tx_inv_r, tx_mod_r, rx_bb_r, rx_inv_r, rx_dis_r;
  opc_src_t        tx_sel_r;
  opc_duty_t       duty_r;
  logic            aw_hold_r, w_hold_r;
  logic [OPC_ADDR_W-1:0] awaddr_r;
  logic [31:0]     wdata_r;
  logic [3:0]      wstrb_r;
  logic            do_write;
  logic [31:0]     rd_val;
  logic            rd_hit;
  logic            carrier_r;

  assign do_write = aw_hold_r && w_hold_r && !s_axi_bvalid;

  // address and data are latched independently so either may arrive first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r     <= 1'b0;
      w_hold_r      <= 1'b0;
      awaddr_r      <= '0;
      wdata_r       <= '0;
      wstrb_r       <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= !aw_hold_r && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_hold_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end else if (do_write) begin
        aw_hold_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end else if (do_write) begin
        w_hold_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= OPC_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (awaddr_r == OPC_ADDR_TXCFG || awaddr_r == OPC_ADDR_RXCFG ||
                       awaddr_r == OPC_ADDR_STATUS) ? OPC_RESP_OKAY : OPC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // only byte lane 0 holds fields; other lanes are ignored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_inv_r <= 1'b0;
      tx_mod_r <= 1'b0;
      tx_sel_r <= opc_src_t'(OPC_SEL_RESET);
      rx_bb_r  <= 1'b0;
      rx_inv_r <= 1'b0;
      rx_dis_r <= 1'b0;
      duty_r   <= opc_duty_t'(OPC_DUTY_RESET);
    end else if (do_write && wstrb_r[0]) begin
      if (awaddr_r == OPC_ADDR_TXCFG) begin
        tx_inv_r <= wdata_r[OPC_TX_INV_BIT];
        tx_mod_r <= wdata_r[OPC_TX_MOD_BIT];
        tx_sel_r <= opc_src_t'(wdata_r[OPC_TX_SEL_LO +: 2]);
      end
      if (awaddr_r == OPC_ADDR_RXCFG) begin
        rx_bb_r  <= wdata_r[OPC_RX_BB_BIT];
        rx_inv_r <= wdata_r[OPC_RX_INV_BIT];
        rx_dis_r <= wdata_r[OPC_RX_DIS_BIT];
        duty_r   <= opc_duty_t'(wdata_r[OPC_DUTY_LO +: 2]);
      end
    end
  end

  // ==========================================================
  // read channel
  always_comb begin
    rd_val = '0;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      OPC_ADDR_TXCFG: begin
        rd_val[OPC_TX_INV_BIT]        = tx_inv_r;
        rd_val[OPC_TX_MOD_BIT]        = tx_mod_r;
        rd_val[OPC_TX_SEL_LO +: 2]    = tx_sel_r;
      end
      OPC_ADDR_RXCFG: begin
        rd_val[OPC_RX_BB_BIT]         = rx_bb_r;
        rd_val[OPC_RX_INV_BIT]        = rx_inv_r;
        rd_val[OPC_RX_DIS_BIT]        = rx_dis_r;
        rd_val[OPC_DUTY_LO +: 2]      = duty_r;
      end
      OPC_ADDR_STATUS: begin
        rd_val[OPC_ST_TX_BIT]         = optical_tx_pin;
        rd_val[OPC_ST_RX_BIT]         = optical_rx_pin;
        rd_val[OPC_ST_CAR_BIT]        = carrier_r;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= OPC_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_val;
        s_axi_rresp  <= rd_hit ? OPC_RESP_OKAY : OPC_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // carrier generation
  // divider gives one enable per carrier phase step; sixteen steps per period
  localparam int DIV_W = $clog2(CAR_DIV + 1);
  logic [DIV_W-1:0]       div_r;
  logic [OPC_PHASE_W-1:0] phase_r;
  logic                   low_nxt;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_r   <= '0;
      phase_r <= '0;
    end else if (div_r == DIV_W'(CAR_DIV - 1)) begin
      div_r   <= '0;
      phase_r <= phase_r + 1'b1;
    end else begin
      div_r   <= div_r + 1'b1;
    end
  end

  // low while phase is in the first 8, 4, 2 or 1 of 16 steps
  always_comb begin
    case (duty_r)
      OPC_DUTY_50: low_nxt = (phase_r[3] == 1'b0);
      OPC_DUTY_25: low_nxt = (phase_r[3:2] == 2'h0);
      OPC_DUTY_12: low_nxt = (phase_r[3:1] == 3'h0);
      OPC_DUTY_6:  low_nxt = (phase_r == 4'h0);
      default:     low_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) carrier_r <= 1'b0;
    else          carrier_r <= !low_nxt;
  end

  // ==========================================================
  // transmit path
  logic tx_src, tx_inv, tx_out;
  always_comb begin
    case (tx_sel_r)
      OPC_SRC_GPIO:  tx_src = gpio_out_51;
      OPC_SRC_UART:  tx_src = uart_tx_data;
      OPC_SRC_REAL:  tx_src = real_energy_pulse;
      OPC_SRC_REACT: tx_src = reactive_energy_pulse;
      default:       tx_src = gpio_out_51;
    endcase
  end
  assign tx_inv = tx_src ^ tx_inv_r;
  // zero test sees the inverted level so idle-high sources still modulate
  assign tx_out = (tx_mod_r && !tx_inv) ? carrier_r : tx_inv;

  always_ff @(posedge aclk) begin
    if (!aresetn) optical_tx_pin <= 1'b0;
    else          optical_tx_pin <= segment_pin_map_51 ? lcd_segment_51 : tx_out;
  end

  // ==========================================================
  // receive path
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      uart_rx_data           <= 1'b1;
      gpio_in_55             <= 1'b0;
      shared_segment_gpio_55 <= 1'b0;
      bitbang_active         <= 1'b0;
    end else begin
      // uart idles high when not routed so the receiver sees no start bit
      uart_rx_data <= (!rx_dis_r && !rx_bb_r && !segment_pin_map_55) ?
                      (optical_rx_pin ^ rx_inv_r) : 1'b1;
      gpio_in_55   <= (!segment_pin_map_55 && (rx_dis_r || rx_bb_r)) ?
                      optical_rx_pin : 1'b0;
      shared_segment_gpio_55 <= segment_pin_map_55;
      bitbang_active         <= rx_bb_r && !segment_pin_map_55;
    end
  end

  // ==========================================================
  // checks
  // every pin output is registered, so each check looks one edge after its cause
  a_tx_invert_path: assert property (@(posedge aclk) disable iff (!aresetn)
    (!segment_pin_map_51 && !tx_mod_r) |=> optical_tx_pin == $past(tx_src ^ tx_inv_r))
    else $error("tx pin not inverted source");
  a_tx_modulate_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    (!segment_pin_map_51 && tx_mod_r && !tx_inv) |=> optical_tx_pin == $past(carrier_r))
    else $error("tx zero not modulated");
  a_tx_one_passes: assert property (@(posedge aclk) disable iff (!aresetn)
    (!segment_pin_map_51 && tx_inv) |=> optical_tx_pin)
    else $error("tx high level lost");
  a_tx_segment_wins: assert property (@(posedge aclk) disable iff (!aresetn)
    segment_pin_map_51 |=> optical_tx_pin == $past(lcd_segment_51))
    else $error("segment not driving tx pin");
  a_duty_six_low: assert property (@(posedge aclk) disable iff (!aresetn)
    (duty_r == OPC_DUTY_6 && phase_r != 4'h0) |=> carrier_r)
    else $error("carrier low outside duty");
  a_duty_half_low: assert property (@(posedge aclk) disable iff (!aresetn)
    (duty_r == OPC_DUTY_50) |=> carrier_r == $past(phase_r[3]))
    else $error("carrier half duty wrong");
  a_rx_uart_route: assert property (@(posedge aclk) disable iff (!aresetn)
    (!rx_dis_r && !rx_bb_r && !segment_pin_map_55) |=>
      uart_rx_data == ($past(optical_rx_pin) ^ $past(rx_inv_r)))
    else $error("uart rx wrong");
  a_rx_gpio_raw: assert property (@(posedge aclk) disable iff (!aresetn)
    (rx_dis_r && !segment_pin_map_55) |=> gpio_in_55 == $past(optical_rx_pin))
    else $error("gpio rx inverted");
  a_rx_gpio_idle: assert property (@(posedge aclk) disable iff (!aresetn)
    (!rx_dis_r && !rx_bb_r) |=> !gpio_in_55)
    else $error("gpio rx active while uart owns pin");
  a_rx_segment_owns: assert property (@(posedge aclk) disable iff (!aresetn)
    segment_pin_map_55 |=> uart_rx_data && !gpio_in_55 && shared_segment_gpio_55)
    else $error("rx pin not released to segment");
  a_rx_bitbang_gpio: assert property (@(posedge aclk) disable iff (!aresetn)
    (rx_bb_r && !segment_pin_map_55) |=> bitbang_active && uart_rx_data)
    else $error("bitbang not gpio");
  a_car_div_step: assert property (@(posedge aclk) disable iff (!aresetn)
    (div_r != DIV_W'(CAR_DIV - 1)) |=> phase_r == $past(phase_r))
    else $error("phase moved early");
  a_phase_advance: assert property (@(posedge aclk) disable iff (!aresetn)
    (div_r == DIV_W'(CAR_DIV - 1)) |=> phase_r == OPC_PHASE_W'($past(phase_r) + 1'b1))
    else $error("phase did not advance");
  a_read_resp_once: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_rvalid && s_axi_rready) |=> !s_axi_rvalid)
    else $error("read response repeated");
endmodule

/* File: design/opc_pkg.sv */
// package for the optical port pin conditioning block
// assumes a 32-bit axi4-lite register bus; offsets printed as indices
package opc_pkg;
  // printed register offsets kept as indices; byte address is four times
  localparam logic [15:0] OPC_IDX_TXCFG   = 16'h2456;
  localparam logic [15:0] OPC_IDX_RXCFG   = 16'h2457;
  localparam logic [15:0] OPC_IDX_STATUS  = 16'h2458;
  localparam int          OPC_ADDR_W      = 18;
  localparam logic [OPC_ADDR_W-1:0] OPC_ADDR_TXCFG  = {OPC_IDX_TXCFG, 2'b00};
  localparam logic [OPC_ADDR_W-1:0] OPC_ADDR_RXCFG  = {OPC_IDX_RXCFG, 2'b00};
  localparam logic [OPC_ADDR_W-1:0] OPC_ADDR_STATUS = {OPC_IDX_STATUS, 2'b00};
  // tx config field positions
  localparam int OPC_TX_INV_BIT = 0;
  localparam int OPC_TX_MOD_BIT = 1;
  localparam int OPC_TX_SEL_LO  = 2;
  // rx config field positions
  localparam int OPC_RX_BB_BIT  = 0;
  localparam int OPC_RX_INV_BIT = 1;
  localparam int OPC_RX_DIS_BIT = 2;
  localparam int OPC_DUTY_LO    = 4;
  // status field positions
  localparam int OPC_ST_TX_BIT  = 0;
  localparam int OPC_ST_RX_BIT  = 1;
  localparam int OPC_ST_CAR_BIT = 2;
  localparam logic [1:0] OPC_RESP_OKAY   = 2'b00;
  localparam logic [1:0] OPC_RESP_SLVERR = 2'b10;
  localparam logic [1:0] OPC_SEL_RESET   = 2'h0;
  localparam logic [1:0] OPC_DUTY_RESET  = 2'h0;
  localparam int OPC_CAR_DIV_DEF = 16;
  localparam int OPC_PHASE_W     = 4;
  typedef enum logic [1:0] {
    OPC_SRC_GPIO, OPC_SRC_UART, OPC_SRC_REAL, OPC_SRC_REACT
  } opc_src_t;
  typedef enum logic [1:0] {
    OPC_DUTY_50, OPC_DUTY_25, OPC_DUTY_12, OPC_DUTY_6
  } opc_duty_t;
endpackage

/* File: sim/opc_ir_partner.sv */
// infrared led and optical receiver facing the optical port pins
// assumes the tx pin is a registered level on aclk
module opc_ir_partner (
  input  wire logic       aclk,
  input  wire logic       optical_tx_pin,
  input  wire logic       rx_level,
  input  wire logic       count_en,
  output logic            optical_rx_pin,
  output logic [7:0]      low_count
);
  timeunit 1ns;
  timeprecision 1ps;
  logic count_en_q;
  // =====================================================
  // receiver and led observation
  // comparator output follows the light level the bench commands
  assign optical_rx_pin = rx_level;
  // led-off cycles counted over one window; count holds once the window closes
  always_ff @(posedge aclk) begin
    count_en_q <= count_en;
    if (count_en && !count_en_q) low_count <= {7'h00, !optical_tx_pin};
    else if (count_en) low_count <= low_count + {7'h00, !optical_tx_pin};
  end
endmodule

/* File: sim/tb_opc_port.sv */
// self-checking bench for the optical port pin conditioning block
// assumes opc_pkg, opc_port and opc_ir_partner; carrier divider set to 2
module tb_opc_port;
  timeunit 1ns;
  timeprecision 1ps;
  import opc_pkg::*;
  // divider above 1 so the phase counter really holds between steps
  localparam int CAR_DIV_TB = 2;
  logic [OPC_ADDR_W-1:0] awaddr, araddr;
  logic [31:0]           wdata, rdata, rv;
  logic [1:0]            bresp, rresp, rr;
  logic [7:0]            lows;
  logic                  aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic                  arvalid, arready, rvalid, rready, map51, map55, lcd51, rx_level;
  logic                  gpio51, utx, rpl, vpl, tx, rxp, urx, gin, sseg, bba, cnt_en;
  int                    n_errors, cmp_count, cycles;
  // =====================================================
  // design and far side
  opc_port #(.CAR_DIV(CAR_DIV_TB)) uut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .segment_pin_map_51(map51), .segment_pin_map_55(map55), .gpio_out_51(gpio51),
    .uart_tx_data(utx), .real_energy_pulse(rpl), .reactive_energy_pulse(vpl),
    .lcd_segment_51(lcd51), .optical_rx_pin(rxp), .optical_tx_pin(tx),
    .uart_rx_data(urx), .gpio_in_55(gin), .shared_segment_gpio_55(sseg),
    .bitbang_active(bba));
  opc_ir_partner ir (.aclk(aclk), .optical_tx_pin(tx), .rx_level(rx_level),
    .count_en(cnt_en), .optical_rx_pin(rxp), .low_count(lows));
  // =====================================================
  // clock, timeout and reporting
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      final_report();
    end
  end
  task automatic final_report();
    if (n_errors == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // =====================================================
  // register bus master
  // address and data offered together; bready and rready stay high once raised
  task automatic axw(input logic [OPC_ADDR_W-1:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    rr = bresp;
  endtask
  task automatic axr(input logic [OPC_ADDR_W-1:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rv = rdata;
    rr = rresp;
  endtask
  // =====================================================
  // scenarios
  task automatic t_regs();
    axr(OPC_ADDR_TXCFG);
    chk(rv, 32'h0);
    axr(OPC_ADDR_RXCFG);
    chk(rv, 32'h0);
    axw(OPC_ADDR_TXCFG, 32'h0000000F);
    chk({30'h0, rr}, {30'h0, OPC_RESP_OKAY});
    axr(OPC_ADDR_TXCFG);
    chk(rv, 32'h0000000F);
    axw(OPC_ADDR_RXCFG, 32'h00000037);
    axr(OPC_ADDR_RXCFG);
    chk(rv, 32'h00000037);
    axw(OPC_ADDR_STATUS + 18'h4, 32'h0000000F);
    chk({30'h0, rr}, {30'h0, OPC_RESP_SLVERR});
    axr(OPC_ADDR_STATUS + 18'h4);
    chk({rv[29:0], rr}, {30'h0, OPC_RESP_SLVERR});
    axw(OPC_ADDR_TXCFG, 32'h0);
    axw(OPC_ADDR_RXCFG, 32'h0);
  endtask
  task automatic t_tx_route();
    logic [3:0] src;
    for (int k = 0; k < 16; k++) begin
      axw(OPC_ADDR_TXCFG, {28'h0, k[1:0], 1'b0, k[3]});
      // a miss puts the only high source on the neighbouring selection
      src = 4'h1 << 2'(k[1:0] + 2'(!k[2]));
      {vpl, rpl, utx, gpio51} <= src;
      repeat (3) @(posedge aclk);
      chk({31'h0, tx}, {31'h0, k[2] ^ k[3]});
    end
    axw(OPC_ADDR_TXCFG, 32'h0000000C);
    map51 <= 1'b1;
    for (int b = 0; b < 2; b++) begin
      lcd51 <= b[0];
      {vpl, rpl, utx, gpio51} <= {4{!b[0]}};
      repeat (3) @(posedge aclk);
      chk({31'h0, tx}, {31'h0, b[0]});
    end
    map51 <= 1'b0;
  endtask
  task automatic t_tx_mod();
    {vpl, rpl, utx} <= 3'h7;
    for (int d = 0; d < 4; d++) begin
      axw(OPC_ADDR_RXCFG, 32'(d) << 4);
      for (int m = 0; m < 3; m++) begin
        axw(OPC_ADDR_TXCFG, (m == 2) ? 32'h3 : 32'h2);
        gpio51 <= (m != 0);
        repeat (3) @(posedge aclk);
        cnt_en <= 1'b1;
        // window spans one carrier period of sixteen phase steps
        repeat (16 * CAR_DIV_TB) @(posedge aclk);
        cnt_en <= 1'b0;
        @(posedge aclk);
        chk({24'h0, lows}, (m == 1) ? 32'h0 : 32'((8 * CAR_DIV_TB) >> d));
      end
    end
    axw(OPC_ADDR_TXCFG, 32'h0);
  endtask
  task automatic t_rx();
    logic bb, inv, dis, m55, pin;
    for (int k = 0; k < 32; k++) begin
      {bb, inv, dis, m55, pin} = k[4:0];
      axw(OPC_ADDR_RXCFG, {29'h0, dis, inv, bb});
      map55 <= m55;
      rx_level <= pin;
      repeat (3) @(posedge aclk);
      chk({31'h0, urx}, {31'h0, (dis | bb | m55) ? 1'b1 : pin ^ inv});
      chk({31'h0, gin}, {31'h0, (dis | bb) & !m55 & pin});
      chk({30'h0, bba, sseg}, {30'h0, bb & !m55, m55});
    end
  endtask
  // =====================================================
  // main sequence
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, cnt_en} = 7'h00;
    {map51, map55, lcd51, rx_level, gpio51, utx, rpl, vpl} = 8'h00;
    awaddr = '0;
    araddr = '0;
    wdata = 32'h0;
    n_errors = 0;
    cmp_count = 0;
    cycles = 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_tx_route();
    t_tx_mod();
    t_rx();
    final_report();
  end
endmodule
